// ---- pmt_timer.sv ----
// Period match timer with APB register access
// Behaviour
// - Count and period registers readable and writable
// - Count steps by one per prescaled tick
// - Input divide select gives 1, 4, 16
// - Match asserted while run is set and count equals period
// - Match reloads zero and steps postscaler
// - Match divide select gives ratio one to sixteen
// - Interrupt request when postscaler reaches ratio
// - Run bit two enables or stops counting
// - Reset clears count, period becomes ff
// - Count or control write clears both scalers
// - Control write leaves count unchanged
// - Control bit seven ignored, reads zero
// - Match also drives serial port shift clock
`timescale 1ns/1ps
module pmt_timer (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // APB slave
  input wire pmt_pkg::pmt_apb_req_s apb_req,
  output pmt_pkg::pmt_apb_rsp_s apb_rsp,
  // Timer events
  output pmt_pkg::pmt_event_s timer_evt
);
  import pmt_pkg::*;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic setup_phase;
  logic access_phase;
  logic hit_count;
  logic hit_period;
  logic hit_control;
  logic hit_any;
  logic wr_ok;
  logic wr_count;
  logic wr_period;
  logic wr_control;
  logic clr_scalers;

  assign setup_phase = apb_req.psel & ~apb_req.penable;
  assign access_phase = apb_req.psel & apb_req.penable;
  assign hit_count = (apb_req.paddr == PMT_OFS_COUNT);
  assign hit_period = (apb_req.paddr == PMT_OFS_PERIOD);
  assign hit_control = (apb_req.paddr == PMT_OFS_CONTROL);
  assign hit_any = hit_count | hit_period | hit_control;

  // Only the low byte lane carries register data
  assign wr_ok = access_phase & apb_req.pwrite & apb_req.pstrb[PMT_LANE0];
  assign wr_count = wr_ok & hit_count;
  assign wr_period = wr_ok & hit_period;
  assign wr_control = wr_ok & hit_control;
  assign clr_scalers = wr_count | wr_control;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [PMT_DATA_W-1:0] count;
  logic [PMT_DATA_W-1:0] period;
  pmt_control_s ctl;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      period <= PMT_PERIOD_RESET;
    end else if (wr_period) begin
      period <= apb_req.pwdata[PMT_DATA_W-1:0];
    end
  end

  // Top bit is masked so it never stores
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ctl <= pmt_control_s'(PMT_CONTROL_RESET);
    end else if (wr_control) begin
      ctl <= pmt_control_s'(apb_req.pwdata[PMT_DATA_W-1:0] & PMT_CONTROL_WMASK);
    end
  end

  // ----------------------------------------------------------------
  // Instruction tick
  // ----------------------------------------------------------------
  logic [PMT_PHASE_W-1:0] phase;
  logic instr_tick;

  // Free running, so a control write cannot skew the core clock rate
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      phase <= '0;
    end else begin
      phase <= phase + 1'b1;
    end
  end

  assign instr_tick = (phase == PMT_PHASE_LAST);

  // ----------------------------------------------------------------
  // Prescaler
  // ----------------------------------------------------------------
  logic [PMT_PRE_W-1:0] pre_limit;
  logic [PMT_PRE_W-1:0] pre_cnt;
  logic pre_step;
  logic pre_tick;

  function automatic logic [PMT_PRE_W-1:0] prescale_limit(input pmt_in_div_e sel);
    logic [PMT_PRE_W-1:0] lim;
    lim = PMT_PRE_LIMIT_16;
    case (sel)
      PMT_IN_DIV1: begin
        lim = PMT_PRE_LIMIT_1;
      end
      PMT_IN_DIV4: begin
        lim = PMT_PRE_LIMIT_4;
      end
      default: begin
        lim = PMT_PRE_LIMIT_16;
      end
    endcase
    return lim;
  endfunction : prescale_limit

  assign pre_limit = prescale_limit(ctl.input_divide_sel);

  // Stopped or cleared scalers take no step at all
  assign pre_step = instr_tick & ctl.timer_run & ~clr_scalers;

  pmt_stage_counter #(
    .CNT_W(PMT_PRE_W)
  ) u_prescale (
    .ref_clk(ref_clk),
    .reset(reset),
    .clear(clr_scalers),
    .step(pre_step),
    .limit(pre_limit),
    .count(pre_cnt),
    .wrap(pre_tick)
  );

  // ----------------------------------------------------------------
  // Count and compare
  // ----------------------------------------------------------------
  logic equal;
  logic match_evt;

  assign equal = (count == period);
  assign match_evt = pre_tick & equal;

  // Software write beats a tick in the same cycle
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      count <= PMT_COUNT_RESET;
    end else if (wr_count) begin
      count <= apb_req.pwdata[PMT_DATA_W-1:0];
    end else if (pre_tick) begin
      if (equal) begin
        count <= PMT_COUNT_START;
      end else begin
        // Above period it just runs on and wraps past ff
        count <= count + 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Postscaler
  // ----------------------------------------------------------------
  logic [PMT_POST_W-1:0] post_cnt;
  logic post_wrap;

  pmt_stage_counter #(
    .CNT_W(PMT_POST_W)
  ) u_postscale (
    .ref_clk(ref_clk),
    .reset(reset),
    .clear(clr_scalers),
    .step(match_evt),
    .limit(ctl.match_divide_sel),
    .count(post_cnt),
    .wrap(post_wrap)
  );

  // ----------------------------------------------------------------
  // Event outputs
  // ----------------------------------------------------------------
  logic shift_clk;
  logic irq_req;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      shift_clk <= 1'b0;
    end else begin
      shift_clk <= match_evt;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      irq_req <= 1'b0;
    end else begin
      irq_req <= post_wrap;
    end
  end

  // Level from flops only; gated by run so a stopped timer shows none
  assign timer_evt.timer_match = ctl.timer_run & equal;
  assign timer_evt.shift_clk = shift_clk;
  assign timer_evt.irq_req = irq_req;

  // ----------------------------------------------------------------
  // Read data and response
  // ----------------------------------------------------------------
  logic [PMT_BUS_W-1:0] rd_data;
  logic rd_err;

  // Sampled at setup; zero wait states keep it current enough
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rd_data <= '0;
    end else if (setup_phase) begin
      rd_data <= '0;
      if (!apb_req.pwrite) begin
        if (hit_count) begin
          rd_data[PMT_DATA_W-1:0] <= count;
        end else if (hit_period) begin
          rd_data[PMT_DATA_W-1:0] <= period;
        end else if (hit_control) begin
          rd_data[PMT_DATA_W-1:0] <= ctl & PMT_CONTROL_WMASK;
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rd_err <= 1'b0;
    end else if (setup_phase) begin
      rd_err <= ~hit_any;
    end
  end

  assign apb_rsp.prdata = rd_data;
  assign apb_rsp.pready = 1'b1;
  assign apb_rsp.pslverr = rd_err;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);

  count_write_a: assert property (
    wr_count |=> count == $past(apb_req.pwdata[PMT_DATA_W-1:0]))
    else $error("count write not stored");

  period_read_a: assert property (
    (setup_phase && !apb_req.pwrite && hit_period) ##1 access_phase
      |-> apb_rsp.prdata == {24'h000000, $past(period)})
    else $error("period read data wrong");

  count_step_a: assert property (
    (pre_tick && !equal && !wr_count) |=> count == $past(count) + 8'h01)
    else $error("count did not step by one");

  div_one_a: assert property (@(posedge ref_clk)
    disable iff (reset || wr_ok)
    (pre_tick && ctl.timer_run && ctl.input_divide_sel == PMT_IN_DIV1)
      |=> !pre_tick [*3] ##1 pre_tick)
    else $error("divide by one tick spacing wrong");

  div_four_a: assert property (@(posedge ref_clk)
    disable iff (reset || wr_ok)
    (pre_tick && ctl.timer_run && ctl.input_divide_sel == PMT_IN_DIV4)
      |=> !pre_tick [*8] ##1 !pre_tick [*7] ##1 pre_tick)
    else $error("divide by four tick spacing wrong");

  match_level_a: assert property (
    match_evt |-> timer_evt.timer_match && count == period)
    else $error("match event without match level");

  reload_zero_a: assert property (
    (match_evt && !wr_count) |=> count == PMT_COUNT_START)
    else $error("match did not reload zero");

  post_step_a: assert property (
    (match_evt && !post_wrap) |=> post_cnt == $past(post_cnt) + 4'h1)
    else $error("postscaler did not step on match");

  post_ratio_a: assert property (
    $rose(irq_req) |-> $past(post_cnt) == $past(ctl.match_divide_sel))
    else $error("interrupt at wrong postscale count");

  irq_cause_a: assert property (
    irq_req |-> $past(match_evt) && shift_clk)
    else $error("interrupt without a match");

  irq_pulse_a: assert property (
    irq_req |=> !irq_req [*3])
    else $error("interrupt pulses too close");

  stop_hold_a: assert property (
    (!ctl.timer_run && !wr_count) |=> count == $past(count) && !shift_clk)
    else $error("stopped timer moved");

  stop_scaler_a: assert property (
    (!ctl.timer_run && !clr_scalers) |=> $stable(pre_cnt) && $stable(post_cnt))
    else $error("stopped scalers moved");

  reset_state_a: assert property (@(posedge ref_clk)
    disable iff (1'b0)
    reset |=> count == PMT_COUNT_RESET && period == PMT_PERIOD_RESET
      && pre_cnt == 4'h0 && post_cnt == 4'h0)
    else $error("reset state wrong");

  scaler_clear_a: assert property (
    clr_scalers |=> pre_cnt == 4'h0 && post_cnt == 4'h0)
    else $error("scalers not cleared by write");

  ctl_keeps_a: assert property (
    (wr_control && !wr_count) |=> $stable(count))
    else $error("control write changed count");

  top_bit_a: assert property (
    (setup_phase && !apb_req.pwrite && hit_control)
      |=> apb_rsp.prdata[PMT_BUS_W-1:PMT_DATA_W-1] == 25'h0)
    else $error("control top bit not zero");

  shift_src_a: assert property (
    match_evt |=> shift_clk ##1 !shift_clk)
    else $error("shift clock does not follow match");

  wrap_top_a: assert property (
    (pre_tick && count == PMT_COUNT_TOP && !equal && !wr_count)
      |=> count == PMT_COUNT_START && !shift_clk)
    else $error("count did not wrap through ff");

  // Unmapped words answer with an error and no data
  unmapped_err_a: assert property (
    (setup_phase && !hit_any) |=> apb_rsp.pslverr && apb_rsp.prdata == 32'h00000000)
    else $error("unmapped access not refused");

endmodule : pmt_timer

// ---- pmt_pkg.sv ----
// Shared constants and types of the period match timer
package pmt_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int unsigned PMT_DATA_W = 8;
  localparam int unsigned PMT_ADDR_W = 12;
  localparam int unsigned PMT_BUS_W = 32;
  localparam int unsigned PMT_STRB_W = 4;
  localparam int unsigned PMT_PRE_W = 4;
  localparam int unsigned PMT_POST_W = 4;
  localparam int unsigned PMT_PHASE_W = 2;
  localparam int unsigned PMT_LANE0 = 0;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [11:0] PMT_OFS_COUNT = 12'h000;
  localparam logic [11:0] PMT_OFS_PERIOD = 12'h004;
  localparam logic [11:0] PMT_OFS_CONTROL = 12'h008;

  // ----------------------------------------------------------------
  // Reset values and masks
  // ----------------------------------------------------------------
  localparam logic [7:0] PMT_COUNT_RESET = 8'h00;
  localparam logic [7:0] PMT_COUNT_START = 8'h00;
  localparam logic [7:0] PMT_COUNT_TOP = 8'hff;
  localparam logic [7:0] PMT_PERIOD_RESET = 8'hff;
  localparam logic [7:0] PMT_CONTROL_RESET = 8'h00;
  localparam logic [7:0] PMT_CONTROL_WMASK = 8'h7f;

  // ----------------------------------------------------------------
  // Timing: instruction tick is the oscillator divided by four
  // ----------------------------------------------------------------
  localparam int unsigned PMT_INSTR_DIV = 4;
  localparam logic [1:0] PMT_PHASE_LAST = 2'(PMT_INSTR_DIV - 1);
  localparam logic [3:0] PMT_PRE_LIMIT_1 = 4'h0;
  localparam logic [3:0] PMT_PRE_LIMIT_4 = 4'h3;
  localparam logic [3:0] PMT_PRE_LIMIT_16 = 4'hf;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PMT_IN_DIV1 = 2'h0,
    PMT_IN_DIV4 = 2'h1,
    PMT_IN_DIV16 = 2'h2,
    PMT_IN_DIV16_ALT = 2'h3
  } pmt_in_div_e;

  typedef struct packed {
    logic unused_top;
    logic [3:0] match_divide_sel;
    logic timer_run;
    pmt_in_div_e input_divide_sel;
  } pmt_control_s;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [3:0] pstrb;
  } pmt_apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } pmt_apb_rsp_s;

  typedef struct packed {
    logic timer_match;
    logic shift_clk;
    logic irq_req;
  } pmt_event_s;

endpackage : pmt_pkg

// ---- pmt_stage_counter.sv ----
// Wrapping divider stage used as prescaler and postscaler
`timescale 1ns/1ps
module pmt_stage_counter #(
  parameter int unsigned CNT_W = 4
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Control
  input wire logic clear,
  input wire logic step,
  input wire logic [CNT_W-1:0] limit,
  // Status
  output logic [CNT_W-1:0] count,
  output logic wrap
);

  // Wrap marks the step that completes one full ratio
  assign wrap = step & (count == limit);

  // Clear outranks a step in the same cycle
  always_ff @(posedge ref_clk) begin
    if (reset || clear) begin
      count <= '0;
    end else if (step) begin
      if (wrap) begin
        count <= '0;
      end else begin
        count <= count + 1'b1;
      end
    end
  end

endmodule : pmt_stage_counter

// ---- period_match_timer_tb.sv ----
// Self-checking testbench of the period match timer
`timescale 1ns/1ps
module period_match_timer_tb;
  import pmt_pkg::*;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic ref_clk;
  logic reset;
  pmt_apb_req_s apb_req;
  pmt_apb_rsp_s apb_rsp;
  pmt_event_s timer_evt;
  int n_errors = 0;
  int checked = 0;
  int cyc = 0;
  logic [31:0] rd;
  logic er;
  int t0;
  int t1;
  int pv [3] = '{0, 1, 15};

  pmt_timer DUT (
    .ref_clk(ref_clk),
    .reset(reset),
    .apb_req(apb_req),
    .apb_rsp(apb_rsp),
    .timer_evt(timer_evt)
  );

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) cyc <= cyc + 1;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task give_verdict;
    if (n_errors == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : give_verdict

  // One APB transfer; the master never assumes the wait-state count
  task xfer(input logic w, input logic [11:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a,
                 pwdata: {24'h000000, d}, pstrb: (w ? 4'hf : 4'h0)};
    @(posedge ref_clk);
    apb_req.penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (apb_rsp.pready !== 1'b1 && n < 50);
    check("pready seen", 32'(n < 50), 32'h1);
    rd = apb_rsp.prdata;
    er = apb_rsp.pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask : xfer

  task rd_chk(input string what, input logic [11:0] a, input logic [7:0] exp);
    xfer(1'b0, a, 8'h00);
    check(what, rd, {24'h000000, exp});
  endtask : rd_chk

  // Stop first so the new period and count are loaded on a quiet timer
  task start(input logic [7:0] p, input logic [7:0] c, input logic [7:0] ctl);
    xfer(1'b1, PMT_OFS_CONTROL, 8'h00);
    xfer(1'b1, PMT_OFS_PERIOD, p);
    xfer(1'b1, PMT_OFS_COUNT, c);
    xfer(1'b1, PMT_OFS_CONTROL, ctl);
  endtask : start

  // Edge-sampled event wait, bounded; returns the cycle stamp
  task wait_evt(input bit irq, input int lim, output int t);
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while ((irq ? timer_evt.irq_req : timer_evt.shift_clk) !== 1'b1 && n < lim);
    t = cyc;
    check("event seen", 32'(n < lim), 32'h1);
  endtask : wait_evt

  // ----------------------------------------------------------------
  // Watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (30000) @(posedge ref_clk);
    n_errors++;
    give_verdict();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    apb_req = '0;
    reset = 1'b1;
    repeat (6) @(posedge ref_clk);
    reset <= 1'b0;
    rd_chk("count reset", PMT_OFS_COUNT, 8'h00);
    rd_chk("period reset", PMT_OFS_PERIOD, 8'hff);
    rd_chk("control reset", PMT_OFS_CONTROL, 8'h00);
    xfer(1'b1, PMT_OFS_PERIOD, 8'h5a);
    rd_chk("period rw", PMT_OFS_PERIOD, 8'h5a);
    xfer(1'b1, PMT_OFS_COUNT, 8'h33);
    rd_chk("count rw", PMT_OFS_COUNT, 8'h33);
    xfer(1'b1, PMT_OFS_CONTROL, 8'h80);
    rd_chk("control bit7", PMT_OFS_CONTROL, 8'h00);
    rd_chk("count after ctl write", PMT_OFS_COUNT, 8'h33);
    // Unmapped word: error, no data, no side effect
    xfer(1'b1, 12'h00c, 8'h11);
    check("unmapped write err", 32'(er), 32'h1);
    xfer(1'b0, 12'h00c, 8'h00);
    check("unmapped read err", 32'(er), 32'h1);
    check("unmapped read data", rd, 32'h0);
    repeat (100) @(posedge ref_clk);
    rd_chk("stopped count holds", PMT_OFS_COUNT, 8'h33);

    // Match spacing for every input divide code
    for (int s = 0; s < 4; s++) begin
      start(8'h03, 8'h00, {5'h00, 1'b1, 2'(s)});
      wait_evt(1'b0, 600, t0);
      wait_evt(1'b0, 600, t1);
      check("match spacing", 32'(t1 - t0), 32'(4 * (s == 0 ? 4 : (s == 1 ? 16 : 64))));
      check("irq at 1:1", 32'(timer_evt.irq_req), 32'h1);
    end

    // Postscale ratios
    for (int i = 0; i < 3; i++) begin
      start(8'h01, 8'h00, {1'b0, 4'(pv[i]), 1'b1, 2'b00});
      t0 = cyc;
      wait_evt(1'b1, 400, t1);
      check("first irq not early", 32'((t1 - t0) >= pv[i] * 8), 32'h1);
      wait_evt(1'b1, 400, t0);
      check("irq spacing", 32'(t0 - t1), 32'((pv[i] + 1) * 8));
    end

    // Equality level, gated by run
    start(8'h10, 8'h10, 8'h02);
    @(posedge ref_clk);
    check("match while stopped", 32'(timer_evt.timer_match), 32'h0);
    xfer(1'b1, PMT_OFS_CONTROL, 8'h06);
    @(posedge ref_clk);
    check("match level", 32'(timer_evt.timer_match), 32'h1);

    // Count steps by one per tick
    start(8'hff, 8'h00, 8'h04);
    xfer(1'b0, PMT_OFS_COUNT, 8'h00);
    t0 = int'(rd[7:0]);
    repeat (40) @(posedge ref_clk);
    xfer(1'b0, PMT_OFS_COUNT, 8'h00);
    t1 = int'(rd[7:0]) - t0;
    check("count step", 32'(t1 == 10 || t1 == 11), 32'h1);

    // Count above period must wrap through ff first
    start(8'h02, 8'h00, 8'h04);
    xfer(1'b1, PMT_OFS_COUNT, 8'h05);
    t0 = cyc;
    wait_evt(1'b0, 1200, t1);
    check("wrap before match", 32'((t1 - t0) >= 1000 && (t1 - t0) <= 1020), 32'h1);

    // Reset in mid-run
    @(posedge ref_clk);
    reset <= 1'b1;
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    rd_chk("count after reset", PMT_OFS_COUNT, 8'h00);
    rd_chk("period after reset", PMT_OFS_PERIOD, 8'hff);
    rd_chk("control after reset", PMT_OFS_CONTROL, 8'h00);
    give_verdict();
  end

endmodule : period_match_timer_tb
